//--- smd_serial_port.v
/*
  serial memory download port: sck/mosi/miso programming of a 512x16 flash
  and a 64x8 eeprom while the reset pin and par_mode are low, plus parallel-mode latching
  of command, address and data bytes on osc_input pulses.
  assumes every pin input is asynchronous to clk; sck much slower than clk.
*/
// What this block does
// - serial programming only while reset pin low
// - program/erase accepted only after enable instruction
// - eeprom write self-timed, erases target itself
// - chip erase sets both arrays to ones
// - mosi sampled on sck rising edge
// - miso shifted on sck falling edge
// - every instruction is four bytes
// - osc pulse with code 10 latches command
// - codes 00 address, 01 data, 11 idle
`timescale 1ns/1ps
`include "smd_map.vh"
module smd_serial_port (
  input wire clk,
  input wire rst,
  input wire reset_pin_n,
  input wire sck,
  input wire mosi,
  output wire miso,
  output wire miso_oe,
  input wire par_mode,
  input wire osc_input,
  input wire action_select_hi,
  input wire action_select_lo,
  input wire byte_select,
  input wire [7:0] par_data,
  output wire [7:0] par_command,
  output wire [15:0] par_address,
  output wire [15:0] par_load_data,
  output wire prog_enabled,
  output wire busy,
  output wire cmd_ready
);
  localparam [31:0] WRITE_CYCLES = (`SMD_WRITE_TIME_NS * 1000 + `SMD_CLK_PERIOD_PS - 1) / `SMD_CLK_PERIOD_PS;
  localparam [31:0] ERASE_CYCLES = (`SMD_ERASE_TIME_NS * 1000 + `SMD_CLK_PERIOD_PS - 1) / `SMD_CLK_PERIOD_PS;
  localparam [11:0] WRITE_LAST = WRITE_CYCLES[11:0] - 12'h001;
  localparam [11:0] ERASE_LAST = ERASE_CYCLES[11:0] - 12'h001;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ERASE = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  // two-stage synchroniser for all pins
  reg [15:0] meta_reg;
  reg [15:0] sync_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 16'h0001;
      sync_reg <= 16'h0001;
    end else begin
      meta_reg <= {par_data, byte_select, action_select_lo, action_select_hi, par_mode,
                   osc_input, mosi, sck, reset_pin_n};
      sync_reg <= meta_reg;
    end
  end
  wire s_rst_n = sync_reg[0];
  wire s_sck = sync_reg[1];
  wire s_mosi = sync_reg[2];
  wire s_osc = sync_reg[3];
  wire s_par = sync_reg[4];
  wire [1:0] s_act = {sync_reg[5], sync_reg[6]};
  wire s_bs = sync_reg[7];
  wire [7:0] s_data = sync_reg[15:8];
  wire prog_mode = !s_rst_n && !s_par;

  reg sck_prev_reg;
  reg osc_prev_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_prev_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= s_sck;
      osc_prev_reg <= s_osc;
    end
  end
  wire sck_rise = s_sck && !sck_prev_reg;
  wire sck_fall = !s_sck && sck_prev_reg;
  wire osc_rise = s_osc && !osc_prev_reg;

  // memory arrays
  reg [15:0] flash_mem [0:511];
  reg [7:0] ee_mem [0:63];

  // serial shifter
  reg [30:0] sh_reg;
  reg [4:0] bit_cnt_reg;
  reg [7:0] out_sh_reg;
  reg miso_reg;
  reg rd_go_reg;
  reg [7:0] rd_op_reg;
  reg [15:0] rd_addr_reg;
  reg push_reg;
  reg [31:0] push_data_reg;
  wire [31:0] shift_word = {sh_reg, s_mosi};
  wire [7:0] push_op = shift_word[31:24];
  wire push_is_read = (push_op == `SMD_OP_RD_FLASH_LO) || (push_op == `SMD_OP_RD_FLASH_HI) ||
                      (push_op == `SMD_OP_RD_EE);
  wire [8:0] rd_fl_addr = rd_addr_reg[8:0];
  wire [5:0] rd_ee_addr = rd_addr_reg[5:0];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_reg <= 31'h0000_0000;
      bit_cnt_reg <= 5'h00;
      out_sh_reg <= 8'h00;
      miso_reg <= 1'b0;
      rd_go_reg <= 1'b0;
      rd_op_reg <= 8'h00;
      rd_addr_reg <= 16'h0000;
      push_reg <= 1'b0;
      push_data_reg <= 32'h0000_0000;
    end else begin
      rd_go_reg <= 1'b0;
      push_reg <= 1'b0;
      if (!prog_mode) begin
        bit_cnt_reg <= 5'h00;
        out_sh_reg <= 8'h00;
        miso_reg <= 1'b0;
      end else begin
        if (sck_rise) begin
          sh_reg <= shift_word[30:0];
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == 5'h17) begin
            rd_go_reg <= 1'b1;
            rd_op_reg <= shift_word[23:16];
            rd_addr_reg <= shift_word[15:0];
          end
          if (bit_cnt_reg == 5'h1F) begin
            push_reg <= !push_is_read;
            push_data_reg <= shift_word;
          end
        end
        if (rd_go_reg) begin
          case (rd_op_reg)
            `SMD_OP_RD_FLASH_LO: out_sh_reg <= flash_mem[rd_fl_addr][7:0];
            `SMD_OP_RD_FLASH_HI: out_sh_reg <= flash_mem[rd_fl_addr][15:8];
            `SMD_OP_RD_EE: out_sh_reg <= ee_mem[rd_ee_addr];
            default: out_sh_reg <= 8'h00;
          endcase
        end else if (sck_fall) begin
          miso_reg <= out_sh_reg[7];
          out_sh_reg <= {out_sh_reg[6:0], 1'b0};
        end
      end
    end
  end
  assign miso = miso_reg;
  assign miso_oe = prog_mode;

  // instruction queue between shifter and executor
  wire q_valid;
  wire q_ready;
  wire [31:0] q_data;
  smd_fifo #(
    .WIDTH(`SMD_INSTR_BITS),
    .DEPTH(`SMD_FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_reg),
    .in_ready(cmd_ready),
    .in_data(push_data_reg),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  // executor
  reg [2:0] state_reg;
  reg [11:0] cnt_reg;
  reg [8:0] erase_addr_reg;
  reg enabled_reg;
  assign q_ready = (state_reg == ST_IDLE);
  wire pop = q_valid && q_ready;
  wire [7:0] q_op = q_data[31:24];
  wire q_allowed = pop && enabled_reg && prog_mode;
  wire wr_fl_lo = q_allowed && (q_op == `SMD_OP_WR_FLASH_LO);
  wire wr_fl_hi = q_allowed && (q_op == `SMD_OP_WR_FLASH_HI);
  wire wr_ee = q_allowed && (q_op == `SMD_OP_WR_EE);
  wire do_erase = q_allowed && (q_op == `SMD_OP_CHIP_ERASE);
  wire erasing = (state_reg == ST_ERASE);
  wire [8:0] fl_waddr = erasing ? erase_addr_reg : q_data[16:8];
  wire [5:0] ee_waddr = erasing ? erase_addr_reg[5:0] : q_data[13:8];

  always @(posedge clk) begin
    if (erasing) begin
      flash_mem[fl_waddr] <= `SMD_FLASH_ERASED;
      if (erase_addr_reg <= {3'b000, `SMD_EE_TOP}) begin
        ee_mem[ee_waddr] <= `SMD_EE_ERASED;
      end
    end else begin
      if (wr_fl_lo) begin
        flash_mem[fl_waddr][7:0] <= q_data[7:0];
      end
      if (wr_fl_hi) begin
        flash_mem[fl_waddr][15:8] <= q_data[7:0];
      end
      if (wr_ee) begin
        ee_mem[ee_waddr] <= q_data[7:0];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 12'h000;
      erase_addr_reg <= 9'h000;
      enabled_reg <= 1'b0;
    end else begin
      if (!prog_mode) begin
        enabled_reg <= 1'b0;
      end else if (pop && q_op == `SMD_OP_ENABLE && q_data[23:16] == `SMD_EN_KEY) begin
        enabled_reg <= 1'b1;
      end
      case (state_reg)
        ST_IDLE: begin
          if (do_erase) begin
            state_reg <= ST_ERASE;
            erase_addr_reg <= 9'h000;
          end else if (wr_fl_lo || wr_fl_hi || wr_ee) begin
            state_reg <= ST_WAIT;
            cnt_reg <= WRITE_LAST;
          end
        end
        ST_ERASE: begin
          erase_addr_reg <= erase_addr_reg + 9'h001;
          if (erase_addr_reg == `SMD_FLASH_TOP) begin
            state_reg <= ST_WAIT;
            cnt_reg <= ERASE_LAST;
          end
        end
        ST_WAIT: begin
          cnt_reg <= cnt_reg - 12'h001;
          if (cnt_reg == 12'h000) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  assign prog_enabled = enabled_reg;
  assign busy = (state_reg != ST_IDLE);

  // parallel-mode byte latches
  reg [7:0] par_cmd_reg;
  reg [15:0] par_addr_reg;
  reg [15:0] par_dat_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      par_cmd_reg <= 8'h00;
      par_addr_reg <= 16'h0000;
      par_dat_reg <= 16'h0000;
    end else if (s_par && osc_rise) begin
      case (s_act)
        `SMD_ACT_LOAD_ADDR: begin
          if (s_bs) begin
            par_addr_reg[15:8] <= s_data;
          end else begin
            par_addr_reg[7:0] <= s_data;
          end
        end
        `SMD_ACT_LOAD_DATA: begin
          if (s_bs) begin
            par_dat_reg[15:8] <= s_data;
          end else begin
            par_dat_reg[7:0] <= s_data;
          end
        end
        `SMD_ACT_LOAD_CMD: begin
          par_cmd_reg <= s_data;
        end
        default: par_cmd_reg <= par_cmd_reg;
      endcase
    end
  end
  assign par_command = par_cmd_reg;
  assign par_address = par_addr_reg;
  assign par_load_data = par_dat_reg;
endmodule // smd_serial_port

//--- smd_map.vh
/*
  constants of the serial memory download port: array tops, erased values,
  serial opcodes, parallel action codes, fifo shape and self-timed write and erase times in ns.
  assumes a 200 mhz core clock.
*/
`ifndef SMD_MAP_VH
`define SMD_MAP_VH

`define SMD_CLK_PERIOD_PS 5000
`define SMD_WRITE_TIME_NS 4000
`define SMD_ERASE_TIME_NS 8000

`define SMD_INSTR_BITS 32
`define SMD_FIFO_DEPTH 16
`define SMD_FLASH_TOP 9'h1FF
`define SMD_EE_TOP 6'h3F
`define SMD_FLASH_ERASED 16'hFFFF
`define SMD_EE_ERASED 8'hFF

`define SMD_OP_ENABLE 8'hAC
`define SMD_EN_KEY 8'h53
`define SMD_OP_CHIP_ERASE 8'h80
`define SMD_OP_RD_FLASH_LO 8'h20
`define SMD_OP_RD_FLASH_HI 8'h28
`define SMD_OP_WR_FLASH_LO 8'h40
`define SMD_OP_WR_FLASH_HI 8'h48
`define SMD_OP_RD_EE 8'hA0
`define SMD_OP_WR_EE 8'hC0

`define SMD_ACT_LOAD_ADDR 2'b00
`define SMD_ACT_LOAD_DATA 2'b01
`define SMD_ACT_LOAD_CMD 2'b10
`define SMD_ACT_IDLE 2'b11
`define SMD_CMD_WRITE_FLASH 8'h10

`endif

//--- smd_fifo.v
/*
  synchronous fifo with valid/ready on both sides, width and depth as parameters.
  assumes one clock and an asynchronous active-high reset; depth a power of two.
*/
`timescale 1ns/1ps
module smd_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire empty = (wr_ptr_reg == rd_ptr_reg);
  wire do_wr = in_valid && !full;
  wire do_rd = out_ready && !empty;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  always @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule // smd_fifo

//--- smd_serial_port_props.sv
/* checker of smd_serial_port port behaviour.
   assumes clk 200 mhz, rst async high; bound below. */
`timescale 1ns/1ps
module smd_serial_port_props (
  input wire clk,
  input wire rst,
  input wire reset_pin_n,
  input wire sck,
  input wire mosi,
  input wire miso,
  input wire miso_oe,
  input wire par_mode,
  input wire osc_input,
  input wire action_select_hi,
  input wire action_select_lo,
  input wire byte_select,
  input wire [7:0] par_data,
  input wire [7:0] par_command,
  input wire [15:0] par_address,
  input wire [15:0] par_load_data,
  input wire prog_enabled,
  input wire busy,
  input wire cmd_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  reg [11:0] busy_cnt_reg;
  // length of the current busy stretch
  always @(posedge clk or posedge rst) begin
    if (rst) busy_cnt_reg <= 12'h000;
    else busy_cnt_reg <= busy ? busy_cnt_reg + 12'h001 : 12'h000;
  end
  a_oe_off: assert property (reset_pin_n [*3] |-> !miso_oe) else $error("miso driven");
  a_oe_on: assert property ((!reset_pin_n && !par_mode) [*3] |-> miso_oe) else $error("miso idle");
  a_miso_quiet: assert property (reset_pin_n [*5] |-> !miso) else $error("miso not zero");
  a_enable_drop: assert property (reset_pin_n [*5] |-> !prog_enabled) else $error("enable kept");
  a_busy_gated: assert property ($rose(busy) |-> $past(prog_enabled)) else $error("busy unenabled");
  a_busy_len: assert property ($fell(busy) |-> busy_cnt_reg inside {[799:801], [2111:2113]})
    else $error("busy length");
  a_miso_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso) |->
    !$past(sck, 2) && $past(sck, 5)) else $error("miso off fall");
  a_cmd_src: assert property ($changed(par_command) |-> $past(par_mode, 3) &&
    $past(action_select_hi, 3) && !$past(action_select_lo, 3)) else $error("command load");
  a_addr_src: assert property ($changed(par_address) |-> $past(par_mode, 3) &&
    !$past(action_select_hi, 3) && !$past(action_select_lo, 3)) else $error("address load");
  a_data_src: assert property ($changed(par_load_data) |-> $past(par_mode, 3) &&
    !$past(action_select_hi, 3) && $past(action_select_lo, 3)) else $error("data load");
endmodule // smd_serial_port_props

bind smd_serial_port smd_serial_port_props u_props (.clk(clk), .rst(rst), .reset_pin_n(reset_pin_n),
  .sck(sck), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .par_mode(par_mode), .osc_input(osc_input),
  .action_select_hi(action_select_hi), .action_select_lo(action_select_lo), .byte_select(byte_select),
  .par_data(par_data), .par_command(par_command), .par_address(par_address), .par_load_data(par_load_data),
  .prog_enabled(prog_enabled), .busy(busy), .cmd_ready(cmd_ready));

//--- smd_prog_model.sv
/* programmer model: shifts 32-bit instructions on sck/mosi, gathers miso.
   assumes the device samples on sck rise and drives miso after sck fall. */
`timescale 1ns/1ps
module smd_prog_model (
  output logic sck,
  output logic mosi,
  input wire miso
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
  end
  // sck low 32 ns, high 32 ns, still between frames
  task automatic xfer(input logic [31:0] word, output logic [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      for (i = 31; i >= 0; i--) begin
        mosi = word[i];
        #32;
        rd = {rd[6:0], miso};
        sck = 1'b1;
        #32;
        sck = 1'b0;
      end
      // last fall only shifts a pad bit, not sampled
      #32;
      mosi = 1'b0;
      #100;
    end
  endtask
endmodule // smd_prog_model

//--- serial_memory_download_port_bench.sv
/* bench for smd_serial_port: model on the serial pins, bench on the rest.
   assumes smd_map.vh macros and the programmer model. */
`timescale 1ns/1ps
`include "smd_map.vh"
module serial_memory_download_port_bench;
  logic clk = 1'b0, rst = 1'b1, reset_pin_n = 1'b0, par_mode = 1'b0, osc_input = 1'b0;
  logic action_select_hi = 1'b1, action_select_lo = 1'b1, byte_select = 1'b0;
  logic [7:0] par_data = 8'h00;
  wire sck, mosi, miso, miso_oe, prog_enabled, busy, cmd_ready;
  wire [7:0] par_command;
  wire [15:0] par_address, par_load_data;
  // undriven miso reads as the opposite of the design's value
  wire miso_line = miso_oe ? miso : ~miso;
  integer miscompares = 0, check_count = 0, cycles = 0;
  always #2.5 clk = ~clk;
  smd_serial_port DUT (.clk(clk), .rst(rst), .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .par_mode(par_mode), .osc_input(osc_input), .action_select_hi(action_select_hi),
    .action_select_lo(action_select_lo), .byte_select(byte_select), .par_data(par_data),
    .par_command(par_command), .par_address(par_address), .par_load_data(par_load_data),
    .prog_enabled(prog_enabled), .busy(busy), .cmd_ready(cmd_ready));
  smd_prog_model prog (.sck(sck), .mosi(mosi), .miso(miso_line));
  task chk(input [15:0] exp, input [15:0] got, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task print_verdict;
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      miscompares++;
      print_verdict;
    end
  end
  task xf(input [31:0] w);
    logic [7:0] r;
    prog.xfer(w, r);
  endtask
  task rd(input [31:0] w, input [7:0] exp);
    logic [7:0] r;
    prog.xfer(w, r);
    chk(exp, r, "read data");
  endtask
  task wait_idle;
    integer n, q;
    n = 0;
    q = 0;
    while (q < 10 && n < 20000) begin
      @(posedge clk);
      n++;
      q = (busy === 1'b0) ? q + 1 : 0;
    end
    chk(1, q >= 10, "idle");
  endtask
  task pin(input v);
    @(posedge clk);
    #1 reset_pin_n = v;
    repeat (8) @(posedge clk);
  endtask
  task t_gate;
    pin(1'b1);
    xf({`SMD_OP_ENABLE, `SMD_EN_KEY, 16'h0000});
    chk(0, prog_enabled, "enabled");
    chk(0, miso_oe, "miso_oe");
    pin(1'b0);
    chk(1, miso_oe, "miso_oe");
    xf({`SMD_OP_CHIP_ERASE, 24'h00_0000});
    repeat (20) @(posedge clk);
    chk(0, busy, "busy");
    xf({`SMD_OP_ENABLE, `SMD_EN_KEY, 16'h0000});
    chk(1, prog_enabled, "enabled");
  endtask
  task t_erase;
    xf({`SMD_OP_CHIP_ERASE, 24'h00_0000});
    chk(1, busy, "busy");
    wait_idle;
    rd({`SMD_OP_RD_FLASH_LO, 24'h00_0000}, 8'hFF);
    rd({`SMD_OP_RD_FLASH_HI, 24'h01_FF00}, 8'hFF);
    rd({`SMD_OP_RD_EE, 24'h00_3F00}, 8'hFF);
  endtask
  task t_write;
    pin(1'b1);
    pin(1'b0);
    xf({`SMD_OP_WR_EE, 24'h00_0577});
    xf({`SMD_OP_ENABLE, `SMD_EN_KEY, 16'h0000});
    rd({`SMD_OP_RD_EE, 24'h00_0500}, 8'hFF);
    xf({`SMD_OP_WR_EE, 24'h00_3FA5});
    xf({`SMD_OP_WR_FLASH_LO, 24'h01_FF3C});
    xf({`SMD_OP_WR_FLASH_HI, 24'h01_FFC3});
    xf({`SMD_OP_WR_EE, 24'h00_005A});
    wait_idle;
    rd({`SMD_OP_RD_EE, 24'h00_3F00}, 8'hA5);
    rd({`SMD_OP_RD_FLASH_LO, 24'h01_FF00}, 8'h3C);
    rd({`SMD_OP_RD_FLASH_HI, 24'h01_FF00}, 8'hC3);
    rd({`SMD_OP_RD_EE, 24'h00_0000}, 8'h5A);
    xf({`SMD_OP_WR_EE, 24'h00_3F0F});
    wait_idle;
    rd({`SMD_OP_RD_EE, 24'h00_3F00}, 8'h0F);
  endtask
  task t_fifo;
    integer i;
    logic full;
    full = 1'b0;
    xf({`SMD_OP_CHIP_ERASE, 24'h00_0000});
    for (i = 0; i < 40; i++) begin
      xf({`SMD_OP_WR_EE, 8'h00, i[7:0], i[7:0]});
      if (cmd_ready === 1'b0) full = 1'b1;
    end
    chk(1, full, "fifo full");
    wait_idle;
    chk(1, cmd_ready, "fifo drained");
  endtask
  task pl(input [1:0] code, input b, input [7:0] d);
    @(posedge clk);
    #1 {action_select_hi, action_select_lo} = code;
    byte_select = b;
    par_data = d;
    repeat (4) @(posedge clk);
    #1 osc_input = 1'b1;
    repeat (4) @(posedge clk);
    #1 osc_input = 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task t_par;
    @(posedge clk);
    #1 par_mode = 1'b1;
    pl(`SMD_ACT_LOAD_CMD, 1'b0, `SMD_CMD_WRITE_FLASH);
    chk(`SMD_CMD_WRITE_FLASH, par_command, "par_command");
    chk(0, miso_oe, "miso_oe");
    pl(`SMD_ACT_LOAD_ADDR, 1'b1, 8'h12);
    pl(`SMD_ACT_LOAD_ADDR, 1'b0, 8'h34);
    chk(16'h1234, par_address, "par_address");
    pl(`SMD_ACT_LOAD_DATA, 1'b1, 8'hAB);
    pl(`SMD_ACT_LOAD_DATA, 1'b0, 8'hCD);
    chk(16'hABCD, par_load_data, "par_load_data");
    pl(`SMD_ACT_IDLE, 1'b0, 8'h55);
    chk(`SMD_CMD_WRITE_FLASH, par_command, "par_command");
    chk(16'h1234, par_address, "par_address");
    chk(16'hABCD, par_load_data, "par_load_data");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    // settle time before the first instruction, scaled down
    repeat (4) @(posedge clk);
    t_gate;
    t_erase;
    t_write;
    t_fifo;
    t_par;
    print_verdict;
  end
endmodule // serial_memory_download_port_bench
